// ---- rtl/dio_wait_event_unit.sv ----
// top of the digital line and wait-event unit
// assumes user logic and the line pins share clk_sys; pin levels arrive synchronous
// --------------------------------------------------------------------
// Overview of operation
// - lines are grouped into ports of eight consecutive connector lines
// - any-edge wait stalls until the line toggles or timeout ends
// - falling-edge wait stalls until high to low or timeout ends
// - high-level wait stalls until the line samples high or timeout
// - low-level wait stalls until the line samples low or timeout
// - rising-edge wait stalls until low to high or timeout ends
// - each wait takes a signed timeout counted in clk_sys cycles
// - a zero timeout reports timeout at once
// - a negative timeout waits with no limit
// - a positive timeout limits the wait to that many cycles
// - separate set-output and set-enable operations for lines and triggers
// - the 10 MHz reference is an input only for user logic
// - in slot two left local bus lines act as star triggers
// - each port is arbitrated between two users by a per-port owner bit; line and trigger writes are not
// - digital operations complete within one clock cycle
// --------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "dwe_cfg.svh"
module dio_wait_event_unit
(
   input  wire logic                        clk_sys,
   input  wire logic                        sys_rst,
   // connector pins
   input  wire logic [`DWE_NUM_LINES-1:0]   connector_line_in,
   output logic      [`DWE_NUM_LINES-1:0]   connector_line_out,
   output logic      [`DWE_NUM_LINES-1:0]   connector_line_oe,
   // trigger pins (left local bus / star)
   input  wire logic [`DWE_NUM_TRIG-1:0]    trig_in,
   output logic      [`DWE_NUM_TRIG-1:0]    trig_out,
   output logic      [`DWE_NUM_TRIG-1:0]    trig_oe,
   input  wire logic [`DWE_SLOT_W-1:0]      slot_num,
   output logic                             trig_is_star,
   // backplane reference and its sampled level
   input  wire logic                        ref_clk10_in,
   output logic                             ref_clk10_level,
   // arbitration: per-port owner (0 or 1)
   input  wire logic [`DWE_NUM_PORTS-1:0]   arb_owner,
   // user 0 and user 1 port requests
   input  wire logic [`DWE_NUM_USERS-1:0]   usr_port_wr,
   input  wire logic [`DWE_NUM_USERS-1:0]   usr_port_en_wr,
   input  wire logic [2:0]                  usr_port_sel [`DWE_NUM_USERS],
   input  wire logic [`DWE_PORT_W-1:0]      usr_port_data [`DWE_NUM_USERS],
   // line requests (single user)
   input  wire logic                        line_set_out,
   input  wire logic                        line_set_en,
   input  wire logic [`DWE_LINE_SEL_W-1:0]  line_sel,
   input  wire logic                        line_val,
   input  wire logic                        trig_set_out,
   input  wire logic                        trig_set_en,
   input  wire logic [`DWE_TRIG_SEL_W-1:0]  trig_sel,
   input  wire logic                        trig_val,
   // reads
   input  wire logic [2:0]                  rd_port_sel,
   output logic      [`DWE_PORT_W-1:0]      rd_port_data,
   output logic      [`DWE_NUM_LINES-1:0]   rd_lines,
   // wait operation
   input  wire logic                        wait_start,
   input  wire dwe_pkg::dwe_wait_kind_t     wait_kind,
   input  wire logic [`DWE_LINE_SEL_W-1:0]  wait_line_sel,
   input  wire logic [`DWE_TMO_W-1:0]       wait_timeout,
   output logic                             wait_busy,
   output logic                             wait_done,
   output logic                             wait_timed_out
);
   // ----------------------------------------------------------------
   // output and enable registers
   // ----------------------------------------------------------------
   logic [`DWE_NUM_LINES-1:0] out_val;
   logic [`DWE_NUM_LINES-1:0] out_en;
   logic [`DWE_NUM_TRIG-1:0]  t_val;
   logic [`DWE_NUM_TRIG-1:0]  t_en;
   logic [`DWE_NUM_LINES-1:0] line_sample;
   logic                      wait_line;

   genvar gp;
   generate
      for (gp = 0; gp < `DWE_NUM_PORTS; gp = gp + 1)
      begin : g_port
         logic      u;
         logic      p_wr;
         logic      p_en;
         logic      l_hit;
         logic [`DWE_PORT_W-1:0] d;
         logic [`DWE_PORT_W-1:0] lmask;
         // only the owning user reaches this port
         assign u     = arb_owner[gp];
         assign p_wr  = usr_port_wr[u] && usr_port_sel[u] == 3'(gp);
         assign p_en  = usr_port_en_wr[u] && usr_port_sel[u] == 3'(gp);
         assign d     = usr_port_data[u];
         assign l_hit = (line_sel[5:3] == 3'(gp));
         // each process writes only its own byte, so a line write is merged by mask
         assign lmask = `DWE_PORT_W'(1) << line_sel[2:0];

         always_ff @(posedge clk_sys or posedge sys_rst)
         begin
            if (sys_rst)
               out_val[gp*`DWE_PORT_W +: `DWE_PORT_W] <= '0;
            else if (p_wr)
               out_val[gp*`DWE_PORT_W +: `DWE_PORT_W] <= d;
            else if (line_set_out && l_hit)
               // port and line writes to one port are not merged
               out_val[gp*`DWE_PORT_W +: `DWE_PORT_W] <=
                  (out_val[gp*`DWE_PORT_W +: `DWE_PORT_W] & ~lmask) |
                  ({`DWE_PORT_W{line_val}} & lmask);
         end

         always_ff @(posedge clk_sys or posedge sys_rst)
         begin
            if (sys_rst)
               out_en[gp*`DWE_PORT_W +: `DWE_PORT_W] <= '0;
            else if (p_en)
               out_en[gp*`DWE_PORT_W +: `DWE_PORT_W] <= d;
            else if (line_set_en && l_hit)
               out_en[gp*`DWE_PORT_W +: `DWE_PORT_W] <=
                  (out_en[gp*`DWE_PORT_W +: `DWE_PORT_W] & ~lmask) |
                  ({`DWE_PORT_W{line_val}} & lmask);
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         t_val <= '0;
         t_en  <= '0;
      end
      else
      begin
         if (trig_set_out)
            t_val[trig_sel] <= trig_val;
         if (trig_set_en)
            t_en[trig_sel] <= trig_val;
      end
   end

   // ----------------------------------------------------------------
   // pins and read-back
   // ----------------------------------------------------------------
   assign connector_line_out = out_val;
   assign connector_line_oe  = out_en;
   assign trig_out           = t_val;
   assign trig_oe            = t_en;
   assign trig_is_star       = (slot_num == `DWE_SLOT_W'(`DWE_SLOT_STAR));

   // released lines read the pin, driven lines read their own value
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         line_sample     <= '0;
         ref_clk10_level <= 1'b0;
      end
      else
      begin
         line_sample     <= (connector_line_in & ~out_en) | (out_val & out_en);
         ref_clk10_level <= ref_clk10_in;
      end
   end

   // one-cycle read of a whole port
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         rd_port_data <= '0;
      else
         rd_port_data <= line_sample[rd_port_sel*`DWE_PORT_W +: `DWE_PORT_W];
   end

   assign rd_lines  = line_sample;
   assign wait_line = line_sample[wait_line_sel];

   // ----------------------------------------------------------------
   // wait operation
   // ----------------------------------------------------------------
   dwe_wait_engine u_wait
   (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .start     (wait_start),
      .kind      (wait_kind),
      .timeout   (wait_timeout),
      .line_now  (wait_line),
      .busy      (wait_busy),
      .done      (wait_done),
      .timed_out (wait_timed_out)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_port_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (usr_port_wr[arb_owner[0]] && usr_port_sel[arb_owner[0]] == 3'h0)
      |=> out_val[7:0] == $past(usr_port_data[arb_owner[0]]))
      else $error("port write lost");

   a_release_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!out_en[0]) |=> line_sample[0] == $past(connector_line_in[0]))
      else $error("released line not read back");

   a_star_slot: assert property (@(posedge clk_sys) disable iff (sys_rst)
      trig_is_star == (slot_num == `DWE_SLOT_W'(`DWE_SLOT_STAR)))
      else $error("star trigger role wrong");

   a_line_out_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (line_set_out && usr_port_wr == '0 && line_sel < `DWE_LINE_SEL_W'(`DWE_NUM_LINES))
      |=> connector_line_out[$past(line_sel)] == $past(line_val))
      else $error("line output write lost");

   a_line_en_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (line_set_en && usr_port_en_wr == '0 && line_sel < `DWE_LINE_SEL_W'(`DWE_NUM_LINES))
      |=> connector_line_oe[$past(line_sel)] == $past(line_val))
      else $error("line enable write lost");

   a_trig_out_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      trig_set_out |=> trig_out[$past(trig_sel)] == $past(trig_val))
      else $error("trigger output write lost");

   a_trig_en_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      trig_set_en |=> trig_oe[$past(trig_sel)] == $past(trig_val))
      else $error("trigger enable write lost");

   a_non_owner: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (usr_port_wr[~arb_owner[0]] && !usr_port_wr[arb_owner[0]] && !line_set_out
       && usr_port_sel[~arb_owner[0]] == 3'h0)
      |=> $stable(connector_line_out[7:0]))
      else $error("non-owner reached a port");

   a_ref_copy: assert property (@(posedge clk_sys) disable iff (sys_rst)
      1'b1 |=> ref_clk10_level == $past(ref_clk10_in))
      else $error("reference level not copied");

   a_port_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (rd_port_sel != 3'h7)
      |=> rd_port_data == $past(line_sample[rd_port_sel*`DWE_PORT_W +: `DWE_PORT_W]))
      else $error("port read not in one cycle");

   // a wait shows done once, then the engine is free on the next cycle
   sequence s_wait_done;
      wait_done && wait_busy;
   endsequence

   sequence s_back_idle;
      !wait_done && !wait_busy;
   endsequence

   a_done_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_wait_done |=> s_back_idle)
      else $error("wait did not return to idle");
endmodule : dio_wait_event_unit
`default_nettype wire

// ---- rtl/dwe_cfg.svh ----
// constants for the digital line and wait-event unit
// assumes inclusion by every design file of the block
`ifndef DWE_CFG_SVH
`define DWE_CFG_SVH
`define DWE_PORT_W      8
`define DWE_NUM_PORTS   7
`define DWE_NUM_LINES   56
`define DWE_LINE_SEL_W  6
`define DWE_NUM_TRIG    8
`define DWE_TRIG_SEL_W  3
`define DWE_NUM_USERS   2
`define DWE_TMO_W       32
`define DWE_SLOT_STAR   2
`define DWE_SLOT_W      5
`endif

// ---- rtl/dwe_pkg.sv ----
// types for the digital line and wait-event unit
// assumes dwe_cfg.svh is on the include path
`include "dwe_cfg.svh"
package dwe_pkg;
   typedef enum logic [2:0]
   {
      DWE_WAIT_ANY  = 3'h0,
      DWE_WAIT_FALL = 3'h1,
      DWE_WAIT_HIGH = 3'h2,
      DWE_WAIT_LOW  = 3'h3,
      DWE_WAIT_RISE = 3'h4
   } dwe_wait_kind_t;

   typedef enum logic [1:0]
   {
      DWE_ST_IDLE = 2'h0,
      DWE_ST_WAIT = 2'h1,
      DWE_ST_DONE = 2'h2
   } dwe_state_t;
endpackage : dwe_pkg

// ---- rtl/dwe_wait_engine.sv ----
// wait engine: watches one sampled line for an edge or level, with timeout
// assumes line_now is already synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "dwe_cfg.svh"
module dwe_wait_engine
(
   input  wire logic                    clk_sys,
   input  wire logic                    sys_rst,
   input  wire logic                    start,
   input  wire dwe_pkg::dwe_wait_kind_t kind,
   input  wire logic [`DWE_TMO_W-1:0]   timeout,
   input  wire logic                    line_now,
   output logic                         busy,
   output logic                         done,
   output logic                         timed_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   dwe_pkg::dwe_state_t     state;
   dwe_pkg::dwe_wait_kind_t kind_q;
   logic [`DWE_TMO_W-1:0]   remain;
   logic                    unlimited;
   logic                    line_prev;
   logic                    hit;

   // edges compare against the level seen the cycle before
   always_comb
   begin
      case (kind_q)
         dwe_pkg::DWE_WAIT_ANY:  hit = line_now ^ line_prev;
         dwe_pkg::DWE_WAIT_FALL: hit = line_prev & ~line_now;
         dwe_pkg::DWE_WAIT_HIGH: hit = line_now;
         dwe_pkg::DWE_WAIT_LOW:  hit = ~line_now;
         dwe_pkg::DWE_WAIT_RISE: hit = ~line_prev & line_now;
         default:                hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         line_prev <= 1'b0;
      else
         line_prev <= line_now;
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state     <= dwe_pkg::DWE_ST_IDLE;
         kind_q    <= dwe_pkg::DWE_WAIT_ANY;
         remain    <= '0;
         unlimited <= 1'b0;
         timed_out <= 1'b0;
      end
      else
      begin
         case (state)
            dwe_pkg::DWE_ST_IDLE:
            begin
               if (start)
               begin
                  kind_q    <= kind;
                  remain    <= timeout;
                  unlimited <= timeout[`DWE_TMO_W-1];
                  if (timeout == '0)
                  begin
                     timed_out <= 1'b1;
                     state     <= dwe_pkg::DWE_ST_DONE;
                  end
                  else
                  begin
                     timed_out <= 1'b0;
                     state     <= dwe_pkg::DWE_ST_WAIT;
                  end
               end
            end
            dwe_pkg::DWE_ST_WAIT:
            begin
               if (hit)
               begin
                  timed_out <= 1'b0;
                  state     <= dwe_pkg::DWE_ST_DONE;
               end
               else if (!unlimited && remain == `DWE_TMO_W'(1))
               begin
                  timed_out <= 1'b1;
                  state     <= dwe_pkg::DWE_ST_DONE;
               end
               else if (!unlimited)
                  remain <= remain - `DWE_TMO_W'(1);
            end
            dwe_pkg::DWE_ST_DONE:
               state <= dwe_pkg::DWE_ST_IDLE;
            default:
               state <= dwe_pkg::DWE_ST_IDLE;
         endcase
      end
   end

   assign busy = (state != dwe_pkg::DWE_ST_IDLE);
   assign done = (state == dwe_pkg::DWE_ST_DONE);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_zero_tmo_now: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == dwe_pkg::DWE_ST_IDLE && start && timeout == '0) |=> (done && timed_out))
      else $error("zero timeout did not end at once");

   a_tmo_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == dwe_pkg::DWE_ST_IDLE && start && timeout == `DWE_TMO_W'(3))
      |-> ##[1:4] done)
      else $error("positive timeout overran");

   a_neg_no_tmo: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (done && unlimited && state == dwe_pkg::DWE_ST_DONE) |-> !timed_out)
      else $error("unlimited wait reported a timeout");

   a_hit_ends: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == dwe_pkg::DWE_ST_WAIT && hit) |=> (done && !timed_out))
      else $error("condition did not end wait");

   a_busy_stall: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == dwe_pkg::DWE_ST_WAIT && !hit && unlimited) |=> busy && !done)
      else $error("wait ended without its condition");
endmodule : dwe_wait_engine
`default_nettype wire

// ---- verif/dwe_pin_partner.sv ----
// model of the outside circuitry on a group of two-way pins
// assumes the bench sets ext_val; the block's enables decide who drives
`timescale 1ns/1ps
`default_nettype none
module dwe_pin_partner
#(
   parameter int W = 8
)
(
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe,
   input  wire logic [W-1:0] ext_val,
   output logic      [W-1:0] pin_in
);
   // outside circuit only drives lines the block has released
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : dwe_pin_partner
`default_nettype wire

// ---- verif/dio_wait_event_unit_tb_top.sv ----
// self-checking bench for the digital line and wait-event unit
// assumes dwe_cfg.svh on the include path; inputs change at falling edges
`timescale 1ns/1ps
`default_nettype none
`include "dwe_cfg.svh"
module dio_wait_event_unit_tb_top;
   typedef struct {
      logic [2:0]  kind;
      int          line;
      logic        lv0;
      int          dly;
      logic        lv1;
      logic [31:0] tmo;
      logic        to;
      int          lo;
      int          hi;
   } dwe_row_t;
   logic        clk_sys, sys_rst, trig_is_star, ref_in, ref_lvl, wst, wbusy, wdone, wto;
   logic [55:0] line_in, line_out, line_oe, ext_line, rd_lines;
   logic [7:0]  trig_in, trig_out, trig_oe, ext_trig, rdat;
   logic [7:0]  pdat [2];
   logic [2:0]  psel [2];
   logic [4:0]  slot_num;
   logic [6:0]  arb_owner;
   logic [1:0]  pwr, pen;
   logic        lso, lse, lval, tso, tse, tval;
   logic [5:0]  lsel, wsel;
   logic [2:0]  tsel, rsel;
   logic [31:0] wtmo;
   dwe_pkg::dwe_wait_kind_t wkind;
   int          n_mismatch, checked;
   // kinds: 0 any, 1 fall, 2 high, 3 low, 4 rise; lo..hi is the done cycle
   dwe_row_t rows [10] = '{
      '{3'h0,  3, 1'b0,  3, 1'b1, 32'h14, 1'b0,  4,  7},
      '{3'h1,  9, 1'b1,  3, 1'b0, 32'h14, 1'b0,  4,  7},
      '{3'h4,  9, 1'b0,  3, 1'b1, 32'h14, 1'b0,  4,  7},
      '{3'h2, 17, 1'b1,  0, 1'b1, 32'h0a, 1'b0,  1,  3},
      '{3'h3, 17, 1'b1,  3, 1'b0, 32'h14, 1'b0,  4,  7},
      '{3'h4, 20, 1'b1,  3, 1'b0, 32'h08, 1'b1,  9,  9},
      '{3'h1, 20, 1'b0,  0, 1'b0, 32'h00, 1'b1,  1,  1},
      '{3'h2, 55, 1'b0, 30, 1'b1, 32'hffffffff, 1'b0, 31, 34},
      '{3'h0,  0, 1'b0,  0, 1'b0, 32'h04, 1'b1,  5,  5},
      '{3'h3, 40, 1'b1,  2, 1'b1, 32'h03, 1'b1,  4,  4}
   };
   dio_wait_event_unit i_dio_wait_event_unit (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .connector_line_in(line_in), .connector_line_out(line_out),
      .connector_line_oe(line_oe), .trig_in(trig_in), .trig_out(trig_out),
      .trig_oe(trig_oe), .slot_num(slot_num), .trig_is_star(trig_is_star),
      .ref_clk10_in(ref_in), .ref_clk10_level(ref_lvl), .arb_owner(arb_owner),
      .usr_port_wr(pwr), .usr_port_en_wr(pen), .usr_port_sel(psel),
      .usr_port_data(pdat), .line_set_out(lso), .line_set_en(lse), .line_sel(lsel),
      .line_val(lval), .trig_set_out(tso), .trig_set_en(tse), .trig_sel(tsel),
      .trig_val(tval), .rd_port_sel(rsel), .rd_port_data(rdat), .rd_lines(rd_lines),
      .wait_start(wst), .wait_kind(wkind), .wait_line_sel(wsel),
      .wait_timeout(wtmo), .wait_busy(wbusy), .wait_done(wdone),
      .wait_timed_out(wto));
   dwe_pin_partner #(.W(56)) i_dwe_pin_partner_line (.pin_out(line_out),
      .pin_oe(line_oe), .ext_val(ext_line), .pin_in(line_in));
   dwe_pin_partner #(.W(8)) i_dwe_pin_partner_trig (.pin_out(trig_out),
      .pin_oe(trig_oe), .ext_val(ext_trig), .pin_in(trig_in));
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic chk_val(input logic [55:0] got, input logic [55:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_cnt(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t done cycle %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_cnt
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   task automatic run_row(input dwe_row_t r);
      int n;
      ext_line[r.line] = r.lv0;
      // settle so the edge detector sees no stale transition
      repeat (4) @(negedge clk_sys);
      wkind = dwe_pkg::dwe_wait_kind_t'(r.kind);
      wsel = r.line[5:0];
      wtmo = r.tmo;
      wst = 1'b1;
      fork
         begin
            repeat (r.dly) @(negedge clk_sys);
            ext_line[r.line] = r.lv1;
         end
      join_none
      @(negedge clk_sys);
      wst = 1'b0;
      n = 1;
      while (wdone !== 1'b1 && n < 60)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk_cnt(n, r.lo, r.hi);
      chk_val(56'(wto), 56'(r.to));
      @(negedge clk_sys);
      chk_val(56'(wbusy), 56'h0);
   endtask : run_row
   task automatic port_wr(input int u, input logic [2:0] p, input logic [7:0] d,
                          input logic en);
      @(negedge clk_sys);
      psel[u] = p;
      pdat[u] = d;
      if (en) pen[u] = 1'b1;
      else pwr[u] = 1'b1;
      @(negedge clk_sys);
      pwr = 2'h0;
      pen = 2'h0;
   endtask : port_wr
   task automatic line_wr(input logic en, input logic [5:0] s, input logic v);
      @(negedge clk_sys);
      lsel = s;
      lval = v;
      if (en) lse = 1'b1;
      else lso = 1'b1;
      @(negedge clk_sys);
      lso = 1'b0;
      lse = 1'b0;
   endtask : line_wr
   // -----------------------------------------------------------------
   // clock, watchdog, main sequence
   // -----------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      // the whole sequence needs well under a thousand cycles
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      final_report();
   end
   initial
   begin
      n_mismatch = 0;
      checked = 0;
      sys_rst = 1'b1;
      {ext_line, ext_trig, slot_num, ref_in, arb_owner, pwr, pen} = '0;
      psel = '{3'h0, 3'h0};
      pdat = '{8'h00, 8'h00};
      {lso, lse, lval, tso, tse, tval, lsel, tsel, rsel, wst, wsel, wtmo} = '0;
      wkind = dwe_pkg::DWE_WAIT_ANY;
      repeat (5) @(negedge clk_sys);
      chk_val(line_oe, 56'h0);
      sys_rst = 1'b0;
      foreach (rows[i]) run_row(rows[i]);
      port_wr(0, 3'h2, 8'ha5, 1'b0);
      port_wr(0, 3'h2, 8'hff, 1'b1);
      chk_val(56'({line_oe[23:16], line_out[23:16]}), 56'hffa5);
      rsel = 3'h2;
      repeat (3) @(negedge clk_sys);
      chk_val(56'(rdat), 56'ha5);
      port_wr(1, 3'h2, 8'h3c, 1'b0);
      chk_val(56'(line_out[23:16]), 56'ha5);
      arb_owner[2] = 1'b1;
      port_wr(1, 3'h2, 8'h3c, 1'b0);
      chk_val(56'(line_out[23:16]), 56'h3c);
      @(negedge clk_sys);
      psel[1] = 3'h2;
      pdat[1] = 8'h00;
      lsel = 6'h10;
      lval = 1'b1;
      pwr[1] = 1'b1;
      lso = 1'b1;
      @(negedge clk_sys);
      pwr = 2'h0;
      lso = 1'b0;
      chk_val(56'(line_out[23:16]), 56'h0);
      line_wr(1'b0, 6'h1e, 1'b1);
      line_wr(1'b1, 6'h1e, 1'b1);
      chk_val(56'({line_oe[30], line_out[30]}), 56'h3);
      line_wr(1'b1, 6'h1e, 1'b0);
      repeat (2) @(negedge clk_sys);
      chk_val(56'(rd_lines[30]), 56'h0);
      ext_line[30] = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_val(56'(rd_lines[30]), 56'h1);
      tsel = 3'h5;
      tval = 1'b1;
      tso = 1'b1;
      tse = 1'b1;
      @(negedge clk_sys);
      {tso, tse} = 2'h0;
      chk_val(56'({trig_oe, trig_out}), 56'h2020);
      tval = 1'b0;
      tse = 1'b1;
      @(negedge clk_sys);
      tse = 1'b0;
      chk_val(56'(trig_oe), 56'h0);
      slot_num = 5'h02;
      ref_in = 1'b1;
      @(negedge clk_sys);
      chk_val(56'({trig_is_star, ref_lvl}), 56'h3);
      slot_num = 5'h03;
      #1;
      chk_val(56'(trig_is_star), 56'h0);
      @(negedge clk_sys);
      sys_rst = 1'b1;
      #1;
      chk_val(line_oe | line_out, 56'h0);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      final_report();
   end
endmodule : dio_wait_event_unit_tb_top
`default_nettype wire
